// file: logic/stage_capture_defs.vh
// Register map, field positions, fault mode codes and reset values of the stage capture block.
`ifndef STAGE_CAPTURE_DEFS_VH
`define STAGE_CAPTURE_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_CAP0_LOW     8'h00
`define ADDR_CAP0_HIGH    8'h04
`define ADDR_CAP1_LOW     8'h08
`define ADDR_CAP1_HIGH    8'h0C
`define ADDR_CAP2_LOW     8'h10
`define ADDR_CAP2_HIGH    8'h14
`define ADDR_MATRIX2      8'h18
`define ADDR_MASK0        8'h1C
`define ADDR_MASK1        8'h20
`define ADDR_MASK2        8'h24
`define ADDR_FLAGS0       8'h28
`define ADDR_FLAGS1       8'h2C
`define ADDR_FLAGS2       8'h30
`define ADDR_INCTRL0      8'h34
`define ADDR_INCTRL1      8'h38
`define ADDR_INCTRL2      8'h3C

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_SW_TRIGGER    7
`define BIT_OUT_B_ACT     7
`define BIT_OUT_A_ACT     6
`define BIT_SYNC_ERR      5
`define BIT_EVENT_B       4
`define BIT_EVENT_A       3
`define BIT_CYCLE_END     0
`define MASK_WRITABLE     8'h39
`define FLAGS_W1C         8'hF9
`define INCTRL_CAP_EN     7

// ----------------------------------------------------------------------------
// Fault mode codes and reset values
// ----------------------------------------------------------------------------
`define FM_IGNORE         4'h0
`define FM_JUMP_DT_A      4'h1
`define FM_EXEC_DT        4'h2
`define FM_OPP_WHILE      4'h3
`define FM_DEACTIVATE     4'h4
`define FM_INSERT_DT      4'h5
`define FM_JUMP_DT_B      4'h6
`define FM_HALT           4'h7
`define FM_RETRIG         4'h8
`define FM_RETRIG_FIX     4'h9
`define FM_RETRIG_FIX_OFF 4'hD
`define RESET_BYTE        8'h00
`define RESET_CAPTURE     12'h000

`endif

// file: logic/stage_capture_irq.v
// Fault decode, counter capture, output matrix and flag/mask logic for three power stages.
//
// Behaviour
// (RQ1) Mode zero ignores the selected input; the code still takes it when the block's capture enable is set.
// (RQ2) Modes 1 and 6: jump to opposite dead-time.
// (RQ3) Mode 2: execute full opposite dead-time, wait.
// (RQ4) Mode 3: run opposite while fault active.
// (RQ5) Mode 4: outputs inactive, timing keeps running.
// (RQ6) Mode 5: stop signal, insert dead-time.
// (RQ7) Mode 7: halt stage until software acts.
// (RQ8) Modes 8 and 9: edge retrigger, 9 fixed.
// (RQ9) Mode 13 retrigger plus deactivate; others reserved.
// (RQ10) Software trigger captures; bit shows source.
// (RQ11) Enabled input event loads stage counter.
// (RQ12) 12-bit capture; low read latches shared temp.
// (RQ13) Software never writes capture without trigger.
// (RQ14) Matrix bits set stage 2 output levels.
// (RQ15) Sync error with enable requests interrupt.
// (RQ16) Event A/B with enable requests interrupt.
// (RQ17) Cycle end with enable requests interrupt.
// (RQ18) Output transitions set activity flags, W1C.
// (RQ19) Autorun sync mismatch sets sync error flag.
// (RQ20) Block B event sets flag, W1C.
// (RQ21) Block A event sets flag, W1C.
// (RQ22) Ramp field records ramp of last event.
// (RQ23) Cycle end sets flag, W1C.
// (RQ24) Zero writes and read-only bits ignored.
// (RQ25) Request holds while flag and enable set.
`timescale 1ns/10ps
`include "stage_capture_defs.vh"

module stage_capture_irq (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [35:0] stageCounter,
  input  wire [5:0]  rampIndex,
  input  wire [2:0]  cycleEnd,
  input  wire [2:0]  stageUpdate,
  input  wire [2:0]  autorunEnable,
  input  wire [5:0]  eventInA,
  input  wire [5:0]  eventInB,
  input  wire [2:0]  stageOutputA,
  input  wire [2:0]  stageOutputB,
  input  wire        stage2RawA,
  input  wire        stage2RawB,
  output reg  [2:0]  stageIrq,
  output reg  [11:0] faultActions,
  output reg         stage2OutputA,
  output reg         stage2OutputB
);

  // --------------------------------------------------------------------------
  // Decoded fault actions per stage: bit order is
  // {deact, retrigFixed, retrig, halt, insertDt, oppWhile, execDt, jumpDt}
  // --------------------------------------------------------------------------
  function [7:0] decodeMode;
    input [3:0] mode;
    begin
      decodeMode = 8'h00;
      case (mode)
        // (RQ1) ignored input
        `FM_IGNORE:         decodeMode = 8'h00;
        // (RQ2) jump opposite dead-time
        `FM_JUMP_DT_A:      decodeMode = 8'h01;
        `FM_JUMP_DT_B:      decodeMode = 8'h01;
        // (RQ3) execute opposite dead-time
        `FM_EXEC_DT:        decodeMode = 8'h02;
        // (RQ4) opposite while active
        `FM_OPP_WHILE:      decodeMode = 8'h04;
        // (RQ6) insert dead-time
        `FM_INSERT_DT:      decodeMode = 8'h08;
        // (RQ7) halt stage
        `FM_HALT:           decodeMode = 8'h10;
        // (RQ8) edge retrigger
        `FM_RETRIG:         decodeMode = 8'h20;
        `FM_RETRIG_FIX:     decodeMode = 8'h40;
        // (RQ5) deactivate outputs only
        `FM_DEACTIVATE:     decodeMode = 8'h80;
        // (RQ9) fixed retrigger with deactivate
        `FM_RETRIG_FIX_OFF: decodeMode = 8'hC0;
        default:            decodeMode = 8'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Input synchronisers: three stages, change accepted when last two agree
  // --------------------------------------------------------------------------
  reg  [11:0] syncA_reg;
  reg  [11:0] syncB_reg;
  reg  [11:0] syncC_reg;
  reg  [11:0] inLevel_reg;
  wire [11:0] rawIn = {eventInB, eventInA};
  wire [11:0] agreed = ~(syncB_reg ^ syncC_reg);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      syncA_reg   <= 12'h000;
      syncB_reg   <= 12'h000;
      syncC_reg   <= 12'h000;
      inLevel_reg <= 12'h000;
    end else begin
      syncA_reg   <= rawIn;
      syncB_reg   <= syncA_reg;
      syncC_reg   <= syncB_reg;
      inLevel_reg <= (agreed & syncC_reg) | (~agreed & inLevel_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg [11:0] capVal_reg [0:2];
  reg [2:0]  capSw_reg;
  reg [7:0]  temp_reg;
  reg [7:0]  matrix_reg;
  reg [7:0]  mask_reg [0:2];
  reg [7:0]  flags_reg [0:2];
  reg [7:0]  inCtrl_reg [0:2];
  reg [2:0]  prevOutA_reg;
  reg [2:0]  prevOutB_reg;

  // Input control word per stage: {capEnB, capEnA, two unused bits, mode}; one 4-bit mode serves both blocks.
  // Edge sense is applied upstream, so a rising level is the event.
  reg  [11:0] inPrev_reg;
  wire [11:0] inEdge = inLevel_reg & ~inPrev_reg;

  // --------------------------------------------------------------------------
  // Bus slave: one write and one read under way at a time
  // --------------------------------------------------------------------------
  reg  [7:0]  wAddr_reg;
  reg         wAddrOk_reg;
  reg  [7:0]  wByte_reg;
  reg         wDataOk_reg;
  reg         wByteEn_reg;
  wire        doWrite = wAddrOk_reg & wDataOk_reg & ~bvalid;
  wire [7:0]  wr = wByteEn_reg ? wByte_reg : 8'h00;

  function isMapped;
    input [7:0] a;
    begin
      isMapped = (a[1:0] == 2'b00) && (a <= `ADDR_INCTRL2);
    end
  endfunction

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= 2'b00;
      wAddr_reg   <= 8'h00;
      wAddrOk_reg <= 1'b0;
      wByte_reg   <= 8'h00;
      wDataOk_reg <= 1'b0;
      wByteEn_reg <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        wAddr_reg   <= awaddr;
        wAddrOk_reg <= 1'b1;
        awready     <= 1'b0;
      end
      if (wvalid && wready) begin
        wByte_reg   <= wdata[7:0];
        wByteEn_reg <= wstrb[0];
        wDataOk_reg <= 1'b1;
        wready      <= 1'b0;
      end
      if (doWrite) begin
        bvalid      <= 1'b1;
        bresp       <= isMapped(wAddr_reg) ? 2'b00 : 2'b10;
        wAddrOk_reg <= 1'b0;
        wDataOk_reg <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Write strobes. The function takes all it reads as arguments, so a continuous
  // assignment that calls it follows every change of the write state.
  wire        wrGo = doWrite & wByteEn_reg;

  function wrHit;
    input       go;
    input [7:0] have;
    input [7:0] want;
    begin
      wrHit = go && (have == want);
    end
  endfunction

  wire [2:0] swTrig;
  wire [2:0] maskWr;
  wire [2:0] flagsWr;
  wire [2:0] inCtrlWr;
  assign swTrig[0]   = wrHit(wrGo, wAddr_reg, `ADDR_CAP0_HIGH) && wr[`BIT_SW_TRIGGER];
  assign swTrig[1]   = wrHit(wrGo, wAddr_reg, `ADDR_CAP1_HIGH) && wr[`BIT_SW_TRIGGER];
  assign swTrig[2]   = wrHit(wrGo, wAddr_reg, `ADDR_CAP2_HIGH) && wr[`BIT_SW_TRIGGER];
  assign maskWr[0]   = wrHit(wrGo, wAddr_reg, `ADDR_MASK0);
  assign maskWr[1]   = wrHit(wrGo, wAddr_reg, `ADDR_MASK1);
  assign maskWr[2]   = wrHit(wrGo, wAddr_reg, `ADDR_MASK2);
  assign flagsWr[0]  = wrHit(wrGo, wAddr_reg, `ADDR_FLAGS0);
  assign flagsWr[1]  = wrHit(wrGo, wAddr_reg, `ADDR_FLAGS1);
  assign flagsWr[2]  = wrHit(wrGo, wAddr_reg, `ADDR_FLAGS2);
  assign inCtrlWr[0] = wrHit(wrGo, wAddr_reg, `ADDR_INCTRL0);
  assign inCtrlWr[1] = wrHit(wrGo, wAddr_reg, `ADDR_INCTRL1);
  assign inCtrlWr[2] = wrHit(wrGo, wAddr_reg, `ADDR_INCTRL2);

  // Read channel; a low-byte read is what latches the shared temp register.
  wire       doRead = arvalid && arready;
  reg  [7:0] rdByte;
  reg  [1:0] rdIdx;
  reg        rdLow;

  always @* begin
    rdByte = 8'h00;
    rdIdx  = 2'd0;
    rdLow  = 1'b0;
    case (araddr)
      `ADDR_CAP0_LOW:  begin rdByte = capVal_reg[0][7:0]; rdLow = 1'b1; rdIdx = 2'd0; end
      `ADDR_CAP1_LOW:  begin rdByte = capVal_reg[1][7:0]; rdLow = 1'b1; rdIdx = 2'd1; end
      `ADDR_CAP2_LOW:  begin rdByte = capVal_reg[2][7:0]; rdLow = 1'b1; rdIdx = 2'd2; end
      `ADDR_CAP0_HIGH: rdByte = temp_reg;
      `ADDR_CAP1_HIGH: rdByte = temp_reg;
      `ADDR_CAP2_HIGH: rdByte = temp_reg;
      `ADDR_MATRIX2:   rdByte = matrix_reg;
      `ADDR_MASK0:     rdByte = mask_reg[0];
      `ADDR_MASK1:     rdByte = mask_reg[1];
      `ADDR_MASK2:     rdByte = mask_reg[2];
      `ADDR_FLAGS0:    rdByte = flags_reg[0];
      `ADDR_FLAGS1:    rdByte = flags_reg[1];
      `ADDR_FLAGS2:    rdByte = flags_reg[2];
      `ADDR_INCTRL0:   rdByte = inCtrl_reg[0];
      `ADDR_INCTRL1:   rdByte = inCtrl_reg[1];
      `ADDR_INCTRL2:   rdByte = inCtrl_reg[2];
      default:         rdByte = 8'h00;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'b00;
    end else if (doRead) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h000000, rdByte};
      rresp   <= isMapped(araddr) ? 2'b00 : 2'b10;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Capture, flags and output logic per stage
  // --------------------------------------------------------------------------
  integer     s;
  reg  [2:0]  predEnd;
  wire [5:0]  capHit;
  wire [23:0] flagsNext;
  wire [11:0] actNext;

  always @* begin
    predEnd = {cycleEnd[1] | stageUpdate[1], cycleEnd[0] | stageUpdate[0],
               cycleEnd[2] | stageUpdate[2]};
  end

  // Next flags and fault actions are built per stage here, so that the storage
  // process below only latches them and stays free of blocking temporaries.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : stageLogic
      wire [3:0] mode    = inCtrl_reg[g][3:0];
      wire [7:0] act     = decodeMode(mode);
      wire       edgeA   = inEdge[g*2] | inEdge[g*2 + 1];
      wire       edgeB   = inEdge[6 + g*2] | inEdge[7 + g*2];
      // (RQ1) ignored when mode zero and the block's capture enable is clear
      wire       hitA    = edgeA & ((mode != `FM_IGNORE) | inCtrl_reg[g][6]);
      wire       hitB    = edgeB & ((mode != `FM_IGNORE) | inCtrl_reg[g][7]);
      wire       anyHit  = hitA | hitB;
      wire       faultLv = inLevel_reg[g*2] | inLevel_reg[g*2 + 1] |
                           inLevel_reg[6 + g*2] | inLevel_reg[7 + g*2];
      // (RQ24) only ones clear
      wire [7:0] clr     = flagsWr[g] ? (wr & `FLAGS_W1C) : 8'h00;
      wire [7:0] kept    = flags_reg[g] & ~clr;
      // (RQ19) autorun sync mismatch
      wire       syncBad = autorunEnable[g] & ((cycleEnd[g] | stageUpdate[g]) ^ predEnd[g]);

      // (RQ11) enabled input capture
      assign capHit[g*2 +: 2] = {hitB & inCtrl_reg[g][7], hitA & inCtrl_reg[g][6]};
      // (RQ18) activity flags, set beats clear
      assign flagsNext[g*8 + `BIT_OUT_B_ACT] = kept[`BIT_OUT_B_ACT] |
                                               (stageOutputB[g] ^ prevOutB_reg[g]);
      assign flagsNext[g*8 + `BIT_OUT_A_ACT] = kept[`BIT_OUT_A_ACT] |
                                               (stageOutputA[g] ^ prevOutA_reg[g]);
      assign flagsNext[g*8 + `BIT_SYNC_ERR]  = kept[`BIT_SYNC_ERR] | syncBad;
      // (RQ20) block B event flag
      assign flagsNext[g*8 + `BIT_EVENT_B]   = kept[`BIT_EVENT_B] | hitB;
      // (RQ21) block A event flag
      assign flagsNext[g*8 + `BIT_EVENT_A]   = kept[`BIT_EVENT_A] | hitA;
      // (RQ22) ramp of last event
      assign flagsNext[g*8 + 1 +: 2]         = anyHit ? rampIndex[g*2 +: 2] : kept[2:1];
      // (RQ23) end of cycle flag
      assign flagsNext[g*8 + `BIT_CYCLE_END] = kept[`BIT_CYCLE_END] | cycleEnd[g];
      // (RQ2) (RQ5) (RQ9) fault action bits per stage
      assign actNext[g*4 +: 4] = {act[7] & faultLv, act[4] & anyHit,
                                  (|act[6:5]) & anyHit, (|act[3:0]) & anyHit};
    end
  endgenerate

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (s = 0; s < 3; s = s + 1) begin
        capVal_reg[s] <= `RESET_CAPTURE;
        mask_reg[s]   <= `RESET_BYTE;
        flags_reg[s]  <= `RESET_BYTE;
        inCtrl_reg[s] <= `RESET_BYTE;
      end
      capSw_reg    <= 3'b000;
      temp_reg     <= `RESET_BYTE;
      matrix_reg   <= `RESET_BYTE;
      prevOutA_reg <= 3'b000;
      prevOutB_reg <= 3'b000;
      inPrev_reg   <= 12'h000;
      stageIrq     <= 3'b000;
      faultActions <= 12'h000;
      stage2OutputA <= 1'b0;
      stage2OutputB <= 1'b0;
    end else begin
      inPrev_reg   <= inLevel_reg;
      prevOutA_reg <= stageOutputA;
      prevOutB_reg <= stageOutputB;
      if (doRead && rdLow) begin
        // (RQ12) coherent high byte
        temp_reg <= {capSw_reg[rdIdx], 3'b000, capVal_reg[rdIdx][11:8]};
      end
      if (wrHit(wrGo, wAddr_reg, `ADDR_MATRIX2)) begin
        matrix_reg <= wr;
      end
      for (s = 0; s < 3; s = s + 1) begin
        // (RQ10) (RQ11) trigger or input capture
        if (swTrig[s] || capHit[s*2] || capHit[s*2 + 1]) begin
          capVal_reg[s] <= stageCounter[s*12 +: 12];
          capSw_reg[s]  <= swTrig[s];
        end
        if (maskWr[s]) begin
          mask_reg[s] <= wr & `MASK_WRITABLE;
        end
        if (inCtrlWr[s]) begin
          inCtrl_reg[s] <= wr;
        end
        flags_reg[s] <= flagsNext[s*8 +: 8];
        // (RQ15) (RQ16) (RQ17) (RQ25) level request from registered flags
        stageIrq[s] <= |(flags_reg[s] & mask_reg[s] & `MASK_WRITABLE);
      end
      faultActions <= actNext;
      // (RQ14) matrix drives stage 2 levels
      stage2OutputA <= matrix_reg[{1'b0, rampIndex[5:4]}] & stage2RawA;
      stage2OutputB <= matrix_reg[{1'b1, rampIndex[5:4]}] & stage2RawB;
    end
  end

endmodule

// file: dv/stage_far_model.sv
// Far-side model: stage counters, ramp index and fault input pins.
`timescale 1ns/10ps
module stage_far_model (
  input  wire        mclk,
  input  wire        rst,
  input  wire        run,
  input  wire [5:0]  rampSet,
  input  wire [5:0]  evA,
  input  wire [5:0]  evB,
  output reg  [35:0] stageCounter,
  output reg  [5:0]  rampIndex,
  output reg  [5:0]  eventInA,
  output reg  [5:0]  eventInB
);
  // Counters only move while run is high, so a bench can freeze them before a capture.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      stageCounter <= 36'h0;
      rampIndex <= 6'h0;
      eventInA <= 6'h0;
      eventInB <= 6'h0;
    end else begin
      if (run) begin
        stageCounter <= {stageCounter[35:24] + 12'h003, stageCounter[23:12] + 12'h002,
                         stageCounter[11:0] + 12'h001};
      end
      rampIndex <= rampSet;
      eventInA <= evA;
      eventInB <= evB;
    end
  end
endmodule

// file: dv/stage_capture_irq_sva.sv
// Assertions on the register bus and stage-2 outputs of the capture block.
`timescale 1ns/10ps
module stage_capture_irq_sva (
  input wire        mclk,
  input wire        rst,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire        stage2RawA,
  input wire        stage2RawB,
  input wire        stage2OutputA,
  input wire        stage2OutputB
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_bans;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("no write response");
  property p_bhold;
    bvalid && !bready |=> bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_bblock;
    bvalid |-> !awready && !wready;
  endproperty
  a_bblock: assert property (p_bblock) else $error("write taken early");
  property p_bdone;
    bvalid && bready |=> !bvalid;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rans;
    arvalid && arready |=> rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
  property p_rhold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data unstable");
  property p_rblock;
    rvalid |-> !arready;
  endproperty
  a_rblock: assert property (p_rblock) else $error("read taken early");
  property p_rupper;
    rvalid |-> rdata[31:8] == 24'h0;
  endproperty
  a_rupper: assert property (p_rupper) else $error("upper read bits set");
  property p_offa;
    !stage2RawA && !$past(stage2RawA) |-> !stage2OutputA;
  endproperty
  a_offa: assert property (p_offa) else $error("output A high while off");
  property p_offb;
    !stage2RawB && !$past(stage2RawB) |-> !stage2OutputB;
  endproperty
  a_offb: assert property (p_offb) else $error("output B high while off");
endmodule
bind stage_capture_irq stage_capture_irq_sva stage_capture_irq_sva_i (.mclk, .rst, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready,
  .stage2RawA, .stage2RawB, .stage2OutputA, .stage2OutputB);

// file: dv/tb.sv
// Self-checking bench for the stage capture block.
`timescale 1ns/10ps
`include "stage_capture_defs.vh"
module tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [2:0]  cycleEnd = 3'h0;
  logic [2:0]  stageUpdate = 3'h0;
  logic [2:0]  autorunEnable = 3'h0;
  logic [2:0]  stageOutputA = 3'h0;
  logic [2:0]  stageOutputB = 3'h0;
  logic        stage2RawA = 1'b0;
  logic        stage2RawB = 1'b0;
  logic        run = 1'b0;
  logic [5:0]  rampSet = 6'h0;
  logic [5:0]  evA = 6'h0;
  logic [5:0]  evB = 6'h0;
  logic        awready, wready, bvalid, arready, rvalid, stage2OutputA, stage2OutputB;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  stageIrq;
  logic [11:0] faultActions;
  logic [35:0] stageCounter;
  logic [5:0]  rampIndex, eventInA, eventInB;
  logic [33:0] expq[$];
  logic [1:0]  bexpq[$];
  logic [7:0]  m;
  logic [3:0]  seenAct;
  // Expected action nibble {deactivate, halt, retrigger, dead-time} per mode, mode 15 first.
  localparam logic [63:0] modeActions = 64'h00A0_0022_4118_1110;
  int          seed, fail_count = 0, checks_done = 0;

  stage_capture_irq stage_capture_irq_i (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .stageCounter, .rampIndex, .cycleEnd, .stageUpdate,
    .autorunEnable, .eventInA, .eventInB, .stageOutputA, .stageOutputB, .stage2RawA,
    .stage2RawB, .stageIrq, .faultActions, .stage2OutputA, .stage2OutputB);
  stage_far_model stage_far_model_i (.mclk, .rst, .run, .rampSet, .evA, .evB, .stageCounter,
    .rampIndex, .eventInA, .eventInB);

  always #2.5 mclk = ~mclk;

  // ----
  // Bus tasks and result checking
  // ----
  task automatic check(input string what, input logic [33:0] seen_v, input logic [33:0] exp);
    checks_done++;
    if (seen_v !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen_v);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Ready stays high after a response, so no signal is driven twice in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    bexpq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin @(posedge mclk iff awready); awvalid <= 1'b0; end
      begin @(posedge mclk iff wready); wvalid <= 1'b0; end
    join
    @(posedge mclk iff bvalid);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
    expq.push_back({r, 24'h0, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge mclk iff arready);
    arvalid <= 1'b0;
    @(posedge mclk iff rvalid);
  endtask

  always @(posedge mclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check("write response", bresp, bexpq.pop_front());
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check("read", {rresp, rdata}, expq.pop_front());
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A full run takes under 1,000 cycles; the limit of 40,000 cycles leaves ample margin.
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    seed = 31;
    tick(8);
    rst <= 1'b0;
    tick(1);
    for (int a = 0; a < 64; a += 4) rd(8'(a), 8'h00);
    rd(8'h40, 8'h00, 2'b10);
    wr(`ADDR_MASK0, 8'hFF);
    rd(`ADDR_MASK0, 8'h39);
    wstrb <= 4'h0;
    wr(`ADDR_MASK0, 8'h00);
    wstrb <= 4'h1;
    rd(`ADDR_MASK0, 8'h39);
    wr(8'h40, 8'hFF, 2'b10);
    $display("test reset and mask done");
    cycleEnd <= 3'b001;
    tick(1);
    cycleEnd <= 3'b000;
    tick(3);
    check("irq0 cycle end", stageIrq, 3'b001);
    rd(`ADDR_FLAGS0, 8'h01);
    wr(`ADDR_FLAGS0, 8'h00);
    rd(`ADDR_FLAGS0, 8'h01);
    wr(`ADDR_FLAGS0, 8'h01);
    rd(`ADDR_FLAGS0, 8'h00);
    tick(2);
    check("irq0 cleared", stageIrq, 3'b000);
    $display("test cycle end done");
    run <= 1'b1;
    tick(($random(seed) & 255) + 1);
    run <= 1'b0;
    rampSet <= 6'b000010;
    wr(`ADDR_INCTRL0, 8'h48);
    evA <= 6'h01;
    tick(2);
    evA <= 6'h00;
    tick(10);
    check("irq0 event", stageIrq, 3'b001);
    rd(`ADDR_CAP0_LOW, stageCounter[7:0]);
    rd(`ADDR_CAP0_HIGH, {4'h0, stageCounter[11:8]});
    rd(`ADDR_FLAGS0, 8'h0C);
    wr(`ADDR_FLAGS0, 8'h08);
    rd(`ADDR_FLAGS0, 8'h04);
    $display("test event A done");
    autorunEnable <= 3'b010;
    wr(`ADDR_INCTRL1, 8'h88);
    rampSet <= 6'b001100;
    stageOutputA <= 3'b010;
    stageOutputB <= 3'b010;
    stageUpdate <= 3'b010;
    evB <= 6'h04;
    tick(1);
    stageUpdate <= 3'b000;
    tick(2);
    evB <= 6'h00;
    autorunEnable <= 3'b000;
    tick(10);
    check("irq1 masked", stageIrq[1], 1'b0);
    wr(`ADDR_MASK1, 8'h20);
    tick(3);
    check("irq1 sync", stageIrq[1], 1'b1);
    rd(`ADDR_FLAGS1, 8'hF6);
    rd(`ADDR_CAP1_LOW, stageCounter[19:12]);
    rd(`ADDR_CAP1_HIGH, {4'h0, stageCounter[23:20]});
    wr(`ADDR_FLAGS1, 8'hFF);
    rd(`ADDR_FLAGS1, 8'h06);
    $display("test event B done");
    run <= 1'b1;
    tick(($random(seed) & 255) + 1);
    run <= 1'b0;
    wr(`ADDR_CAP2_HIGH, 8'h80);
    tick(2);
    rd(`ADDR_CAP2_LOW, stageCounter[31:24]);
    rd(`ADDR_CAP2_HIGH, {4'h8, stageCounter[35:32]});
    m = 8'($random(seed));
    wr(`ADDR_MATRIX2, m);
    rd(`ADDR_MATRIX2, m);
    stage2RawA <= 1'b1;
    stage2RawB <= 1'b1;
    for (int r = 0; r < 4; r++) begin
      rampSet <= {r[1:0], 4'h0};
      tick(3);
      check("output A", stage2OutputA, m[r]);
      check("output B", stage2OutputB, m[r + 4]);
    end
    stage2RawA <= 1'b0;
    stage2RawB <= 1'b0;
    $display("test capture and matrix done");
    for (int md = 0; md < 16; md++) begin
      if ((md >= 10 && md <= 12) || md >= 14) continue;
      wr(`ADDR_INCTRL2, {4'h0, md[3:0]});
      tick(4);
      seenAct = 4'h0;
      evA <= 6'h10;
      repeat (8) begin
        @(posedge mclk);
        seenAct = seenAct | faultActions[11:8];
      end
      evA <= 6'h00;
      tick(8);
      check("fault action", seenAct, modeActions[md*4 +: 4]);
    end
    $display("test fault modes done");
    stop_test();
  end
endmodule
